//--- rtl/mfx_ext_cfg.sv
// mfx_ext_cfg: extended configuration byte array, offsets 15 to 173, with per-class behaviour
`timescale 1ns/10ps

// Operation
// RQ1: reserved bytes and positions always read back as zero.
// RQ2: write-only fields take one programming and never show it on reads.
// RQ3: plain read-write fields take one programming, then refuse changes, stay readable.
// RQ4: persistent fields rewrite freely and survive power loss and both resets.
// RQ5: power-cleared fields default on power or hardware reset, not on CMD0.
// RQ6: volatile fields rewrite freely and default on any reset, including CMD0.
// RQ7: protected area size byte reads fixed value meaning four megabytes.
// RQ8: write reliability capability byte reads fixed enhanced-definition code.
// RQ9: partitioning capability byte reports all three partition features.
// RQ10: write reliability select byte at 167 defaults to all five bits set.
// RQ11: byte 130 reads one: id data programmable in double data rate.
// RQ12: host reads the whole array with CMD8 and zero argument.
// RQ13: multi-byte fields little-endian by byte; every volatile field resets to its default.
module mfx_ext_cfg (
	// clock, enable, resets
	input  wire logic                 mclk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 ce_i,
	input  wire logic                 hw_rst_i,
	input  wire logic                 sw_rst_i,
	input  wire logic                 nv_erase_i,
	// byte write from the command decoder
	input  wire mfx_pkg::mfx_wr_t     wr_req_i,
	output logic                      wr_done_o,
	output logic                      wr_reject_o,
	// array read, one byte per request
	input  wire logic                 rd_en_i,
	input  wire logic [7:0]           rd_idx_i,
	output logic                      rd_valid_o,
	output logic [7:0]                rd_data_o,
	// device status shown in read-only bytes
	input  wire mfx_pkg::mfx_status_t status_i,
	// configuration towards the device core
	output mfx_pkg::mfx_cfg_t         cfg_o
);

	localparam int unsigned NB = mfx_pkg::ARRAY_BYTES;

	// ==========================================================================
	// volatile byte cells
	logic [7:0] vbyte [0:NB-1];
	logic [NB-1:0] vacc;

	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_byte
			localparam mfx_pkg::mfx_cls_t GC = mfx_pkg::cls_of(8'(gi));
			if (GC == mfx_pkg::CLS_EP || GC == mfx_pkg::CLS_CP || GC == mfx_pkg::CLS_WO)
			begin : g_cell
				// RQ5 RQ6 class resets
				mfx_vbyte #(
					.CLS  (GC),
					.DFLT (mfx_pkg::dflt_of(8'(gi)))
				) u_cell (
					.mclk_i    (mclk_i),
					.rstn_i    (rstn_i),
					.ce_i      (ce_i),
					.hw_rst_i  (hw_rst_i),
					.sw_rst_i  (sw_rst_i),
					.wr_i      (wr_req_i.en && (wr_req_i.idx == 8'(gi))),
					.wr_data_i (wr_req_i.data),
					.q_o       (vbyte[gi]),
					.acc_o     (vacc[gi])
				);
			end else begin : g_none
				assign vbyte[gi] = mfx_pkg::BYTE_ZERO;
				assign vacc[gi]  = 1'b0;
			end
		end
	endgenerate

	// ==========================================================================
	// write decode
	mfx_pkg::mfx_cls_t wr_cls;
	logic [NB-1:0]     nv_valid;
	logic              wr_nv_ok;
	logic              wr_vol_ok;
	logic              wr_ok;
	logic              wr_trig;

	assign wr_cls    = mfx_pkg::cls_of(wr_req_i.idx);
	// RQ3 refuse a second programming
	assign wr_nv_ok  = wr_req_i.en && (wr_cls == mfx_pkg::CLS_NVE
		|| (wr_cls == mfx_pkg::CLS_OTP && !nv_valid[wr_req_i.idx]));
	assign wr_vol_ok = |vacc;
	assign wr_ok     = wr_nv_ok || wr_vol_ok;
	// triggers only fire on an accepted write-only byte with its start bit set
	assign wr_trig   = wr_vol_ok && wr_req_i.data[mfx_pkg::TRIG_BIT];

	// ==========================================================================
	// nonvolatile store and its validity
	// validity survives power loss too; only a factory erase drops it
	logic [7:0] nv_q;

	// RQ4 written flag survives every reset
	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			if (nv_erase_i)
				nv_valid <= '0;
			else if (wr_nv_ok)
				nv_valid[wr_req_i.idx] <= 1'b1;
		end
	end

	mfx_nvram #(
		.DW (8),
		.AW (mfx_pkg::IDX_W)
	) u_nvram (
		.mclk_i  (mclk_i),
		.ce_i    (ce_i),
		.we_i    (wr_nv_ok && !nv_erase_i),
		.waddr_i (wr_req_i.idx),
		.wdata_i (wr_req_i.data),
		.re_i    (rd_en_i),
		.raddr_i (rd_idx_i),
		.rdata_o (nv_q)
	);

	// ==========================================================================
	// read stage 1: classify and pick the flop-held byte
	mfx_pkg::mfx_cls_t rd_cls;
	logic [7:0]        rd_status;
	logic              rd_is_status;
	logic [7:0]        rd_fixed;

	assign rd_cls       = mfx_pkg::cls_of(rd_idx_i);
	assign rd_is_status = (rd_idx_i == mfx_pkg::OFS_FW_RESULT)
		|| (rd_idx_i == mfx_pkg::OFS_PACK_FAIL) || (rd_idx_i == mfx_pkg::OFS_PACK_STATE)
		|| (rd_idx_i == mfx_pkg::OFS_EXC_FLAGS)
		|| (rd_idx_i == mfx_pkg::OFS_EXC_FLAGS + 8'h01)
		|| (rd_idx_i == mfx_pkg::OFS_GROUPS_REL);
	// RQ13 low byte of a wide status field at the lower offset
	assign rd_status =
		(rd_idx_i == mfx_pkg::OFS_FW_RESULT)  ? status_i.fw_result  :
		(rd_idx_i == mfx_pkg::OFS_PACK_FAIL)  ? status_i.pack_fail  :
		(rd_idx_i == mfx_pkg::OFS_PACK_STATE) ? status_i.pack_state :
		(rd_idx_i == mfx_pkg::OFS_EXC_FLAGS)  ? status_i.exc_flags[7:0] :
		(rd_idx_i == mfx_pkg::OFS_GROUPS_REL) ? status_i.groups_rel :
		status_i.exc_flags[15:8];
	// RQ7 RQ8 RQ9 RQ11 fixed bytes come from the default table
	assign rd_fixed = rd_is_status ? rd_status : mfx_pkg::dflt_of(rd_idx_i);

	mfx_pkg::mfx_cls_t s1_cls;
	logic              s1_valid;
	logic [7:0]        s1_vol;
	logic [7:0]        s1_ro;
	logic [7:0]        s1_dflt;
	logic              s1_nvv;

	// stage 1 registers
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s1_valid <= 1'b0;
			s1_cls   <= mfx_pkg::CLS_RSV;
			s1_vol   <= mfx_pkg::BYTE_ZERO;
			s1_ro    <= mfx_pkg::BYTE_ZERO;
			s1_dflt  <= mfx_pkg::BYTE_ZERO;
			s1_nvv   <= 1'b0;
		end else if (ce_i) begin
			s1_valid <= rd_en_i;
			s1_cls   <= rd_cls;
			s1_vol   <= vbyte[rd_idx_i];
			s1_ro    <= rd_fixed;
			s1_dflt  <= mfx_pkg::dflt_of(rd_idx_i);
			s1_nvv   <= nv_valid[rd_idx_i];
		end
	end

	// ==========================================================================
	// read stage 2: final byte select
	logic [7:0] next_rd_data;

	// RQ1 RQ2 reserved and write-only bytes read as zero
	// RQ10 an unprogrammed stored byte shows its default
	assign next_rd_data =
		(s1_cls == mfx_pkg::CLS_RO)  ? s1_ro :
		(s1_cls == mfx_pkg::CLS_OTP || s1_cls == mfx_pkg::CLS_NVE) ?
			(s1_nvv ? nv_q : s1_dflt) :
		(s1_cls == mfx_pkg::CLS_EP || s1_cls == mfx_pkg::CLS_CP) ? s1_vol :
		mfx_pkg::BYTE_ZERO;

	// answer registers
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= mfx_pkg::BYTE_ZERO;
		end else if (ce_i) begin
			rd_valid_o <= s1_valid;
			rd_data_o  <= s1_valid ? next_rd_data : mfx_pkg::BYTE_ZERO;
		end
	end

	// ==========================================================================
	// write answers and configuration outputs
	mfx_pkg::mfx_cfg_t next_cfg;

	always_comb begin
		next_cfg              = '0;
		next_cfg.cmdq_en      = vbyte[mfx_pkg::OFS_CMDQ_EN][0];
		next_cfg.cache_on     = vbyte[mfx_pkg::OFS_CACHE_CTRL][0];
		next_cfg.mode_sel     = vbyte[mfx_pkg::OFS_MODE_SEL];
		next_cfg.pwr_off      = vbyte[mfx_pkg::OFS_PWR_OFF];
		next_cfg.flush_req    = wr_trig && (wr_req_i.idx == mfx_pkg::OFS_FLUSH);
		next_cfg.bkops_req    = wr_trig && (wr_req_i.idx == mfx_pkg::OFS_BKOPS_GO);
		next_cfg.sanitize_req = wr_trig && (wr_req_i.idx == mfx_pkg::OFS_SANITIZE_GO);
	end

	// pulses last one enabled cycle
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			wr_done_o   <= 1'b0;
			wr_reject_o <= 1'b0;
			cfg_o       <= '0;
		end else if (ce_i) begin
			wr_done_o   <= wr_req_i.en && wr_ok;
			wr_reject_o <= wr_req_i.en && !wr_ok;
			cfg_o       <= next_cfg;
		end
	end

	// ==========================================================================
	// checks
	chk_rsv_reads_zero: assert property (  // RQ1
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && rd_en_i && rd_cls == mfx_pkg::CLS_RSV) ##1 ce_i |=> (rd_data_o == 8'h00))
		else $error("reserved byte read nonzero");

	chk_wo_hidden: assert property (  // RQ2
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && rd_en_i && rd_cls == mfx_pkg::CLS_WO) ##1 ce_i |=> (rd_data_o == 8'h00))
		else $error("write-only byte exposed on read");

	chk_otp_refused: assert property (  // RQ3
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && wr_req_i.en && wr_cls == mfx_pkg::CLS_OTP && nv_valid[wr_req_i.idx])
		|=> (wr_reject_o && !wr_done_o))
		else $error("second programming of one-time byte not refused");

	chk_nv_kept: assert property (  // RQ4
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && !nv_erase_i && !wr_nv_ok && (hw_rst_i || sw_rst_i))
		|=> (nv_valid == $past(nv_valid)))
		else $error("persistent byte lost on reset");

	chk_cp_keeps_cmd0: assert property (  // RQ5
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && sw_rst_i && !hw_rst_i && !wr_req_i.en)
		|=> $stable(vbyte[mfx_pkg::OFS_USER_PROT]))
		else $error("power-cleared byte changed by command reset");

	chk_ep_cleared: assert property (  // RQ6
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && sw_rst_i) ##1 ce_i |-> (vbyte[mfx_pkg::OFS_CMDQ_EN] == 8'h00)
		##1 !cfg_o.cmdq_en)
		else $error("volatile byte not cleared by command reset");

	chk_prot_area: assert property (  // RQ7
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && rd_en_i && rd_idx_i == 8'ha8) ##1 ce_i |=> (rd_data_o == 8'h20))
		else $error("protected area size wrong");

	chk_wrrel_caps: assert property (  // RQ8
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && rd_en_i && rd_idx_i == 8'ha6) ##1 ce_i |=> (rd_data_o == 8'h15))
		else $error("write reliability capability wrong");

	chk_part_caps: assert property (  // RQ9
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && rd_en_i && rd_idx_i == 8'ha0) ##1 ce_i |=> (rd_data_o == 8'h07))
		else $error("partitioning capability wrong");

	chk_wrrel_default: assert property (  // RQ10
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && rd_en_i && rd_idx_i == 8'ha7 && !nv_valid[8'ha7]) ##1 ce_i
		|=> (rd_data_o == 8'h1f))
		else $error("write reliability select default wrong");

	chk_ddr_id_prog: assert property (  // RQ11
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && rd_en_i && rd_idx_i == 8'h82) ##1 ce_i |=> (rd_data_o == 8'h01))
		else $error("ddr id program support wrong");

	// every taken write gets exactly one answer, even when ce_i drops after it
	chk_wr_answered: assert property (  // RQ3
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && wr_req_i.en) |=> (wr_done_o != wr_reject_o))
		else $error("write not answered exactly once");

	chk_ro_refused: assert property (  // RQ8
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && wr_req_i.en && wr_cls == mfx_pkg::CLS_RO) |=> wr_reject_o)
		else $error("write to read-only byte not refused");

	chk_cp_hw_clear: assert property (  // RQ5
		@(posedge mclk_i) disable iff (!rstn_i)
		(ce_i && hw_rst_i) |=> (vbyte[mfx_pkg::OFS_USER_PROT] == 8'h00))
		else $error("power-cleared byte kept through hardware reset");

endmodule // mfx_ext_cfg

//--- common/mfx_pkg.sv
// mfx_pkg: shared constants, access classes and carriers of the extended config array
package mfx_pkg;

	// ==========================================================================
	// array geometry
	localparam int unsigned ARRAY_BYTES = 256;
	localparam int unsigned IDX_W       = 8;
	localparam int unsigned READ_LAT    = 2;

	// ==========================================================================
	// byte offsets
	localparam logic [7:0] OFS_CMDQ_EN      = 8'h0f;
	localparam logic [7:0] OFS_SEC_REMOVAL  = 8'h10;
	localparam logic [7:0] OFS_PROD_AWR_EN  = 8'h11;
	localparam logic [7:0] OFS_MAX_PRELOAD  = 8'h12;
	localparam logic [7:0] OFS_PRELOAD      = 8'h16;
	localparam logic [7:0] OFS_FW_RESULT    = 8'h1a;
	localparam logic [7:0] OFS_MODE_OP      = 8'h1d;
	localparam logic [7:0] OFS_MODE_SEL     = 8'h1e;
	localparam logic [7:0] OFS_BARRIER      = 8'h1f;
	localparam logic [7:0] OFS_FLUSH        = 8'h20;
	localparam logic [7:0] OFS_CACHE_CTRL   = 8'h21;
	localparam logic [7:0] OFS_PWR_OFF      = 8'h22;
	localparam logic [7:0] OFS_PACK_FAIL    = 8'h23;
	localparam logic [7:0] OFS_PACK_STATE   = 8'h24;
	localparam logic [7:0] OFS_CONTEXT      = 8'h25;
	localparam logic [7:0] OFS_EXT_PART     = 8'h34;
	localparam logic [7:0] OFS_EXC_FLAGS    = 8'h36;
	localparam logic [7:0] OFS_EXC_MASK     = 8'h38;
	localparam logic [7:0] OFS_GROUPS_REL   = 8'h3a;
	localparam logic [7:0] OFS_PROT_CLASS   = 8'h3b;
	localparam logic [7:0] OFS_FIRST_INIT   = 8'h3c;
	localparam logic [7:0] OFS_CUR_SECTOR   = 8'h3d;
	localparam logic [7:0] OFS_SECTOR_EMUL  = 8'h3e;
	localparam logic [7:0] OFS_PHYS_SECTOR  = 8'h3f;
	localparam logic [7:0] OFS_MAKER_PRIV   = 8'h40;
	localparam logic [7:0] OFS_MAKER_END    = 8'h7f;
	localparam logic [7:0] OFS_DDR_ID_PROG  = 8'h82;
	localparam logic [7:0] OFS_PERIODIC     = 8'h83;
	localparam logic [7:0] OFS_CASE_TEMP    = 8'h84;
	localparam logic [7:0] OFS_PROD_AWR     = 8'h85;
	localparam logic [7:0] OFS_SEC_BADBLK   = 8'h86;
	localparam logic [7:0] OFS_ENH_START    = 8'h88;
	localparam logic [7:0] OFS_PART_DONE    = 8'h9b;
	localparam logic [7:0] OFS_PART_ATTR    = 8'h9c;
	localparam logic [7:0] OFS_MAX_ENH      = 8'h9d;
	localparam logic [7:0] OFS_PART_CAP     = 8'ha0;
	localparam logic [7:0] OFS_PRIORITY_INTERRUPT_MGMT     = 8'ha1;
	localparam logic [7:0] OFS_RST_PIN_FN   = 8'ha2;
	localparam logic [7:0] OFS_BACKGROUND_OPS_ENABLE     = 8'ha3;
	localparam logic [7:0] OFS_BKOPS_GO     = 8'ha4;
	localparam logic [7:0] OFS_SANITIZE_GO  = 8'ha5;
	localparam logic [7:0] OFS_WRREL_CAPS   = 8'ha6;
	localparam logic [7:0] OFS_WRREL_SEL    = 8'ha7;
	localparam logic [7:0] OFS_PROT_AREA    = 8'ha8;
	localparam logic [7:0] OFS_FW_LOCK      = 8'ha9;
	localparam logic [7:0] OFS_USER_PROT    = 8'hab;
	localparam logic [7:0] OFS_BOOT_PROT    = 8'had;

	// ==========================================================================
	// reset and fixed values
	localparam logic [7:0]  DFLT_SEC_REMOVAL = 8'h09;
	localparam logic [7:0]  DFLT_DDR_ID_PROG = 8'h01;
	localparam logic [7:0]  DFLT_PART_CAP    = 8'h07;
	localparam logic [7:0]  DFLT_WRREL_CAPS  = 8'h15;
	localparam logic [7:0]  DFLT_WRREL_SEL   = 8'h1f;
	localparam logic [7:0]  DFLT_PROT_AREA   = 8'h20;
	localparam logic [31:0] DFLT_MAX_PRELOAD = 32'h0000_0000;
	localparam logic [23:0] DFLT_MAX_ENH     = 24'h00_0000;
	localparam logic [7:0]  BYTE_ZERO        = 8'h00;
	localparam int unsigned TRIG_BIT         = 0;

	// ==========================================================================
	// access classes, one-hot
	typedef enum logic [6:0] {
		CLS_RSV = 7'b000_0001,  // reserved, reads zero
		CLS_RO  = 7'b000_0010,  // fixed or device status
		CLS_OTP = 7'b000_0100,  // one programming, readable, kept
		CLS_NVE = 7'b000_1000,  // rewritable, kept through every reset
		CLS_CP  = 7'b001_0000,  // cleared by power and hardware reset only
		CLS_EP  = 7'b010_0000,  // cleared by every reset
		CLS_WO  = 7'b100_0000   // one programming per reset, never read back
	} mfx_cls_t;

	// ==========================================================================
	// carriers
	typedef struct packed {
		logic       en;
		logic [7:0] idx;
		logic [7:0] data;
	} mfx_wr_t;

	typedef struct packed {
		logic [7:0]  fw_result;
		logic [7:0]  pack_fail;
		logic [7:0]  pack_state;
		logic [15:0] exc_flags;
		logic [7:0]  groups_rel;
	} mfx_status_t;

	typedef struct packed {
		logic       cmdq_en;
		logic       cache_on;
		logic [7:0] mode_sel;
		logic [7:0] pwr_off;
		logic       flush_req;
		logic       bkops_req;
		logic       sanitize_req;
	} mfx_cfg_t;

	// ==========================================================================
	// class of each byte offset
	function automatic mfx_cls_t cls_of(input logic [7:0] i);
		mfx_cls_t c;
		c = CLS_RSV;
		if (i == OFS_CMDQ_EN || i == OFS_MODE_SEL || i == OFS_CACHE_CTRL || i == OFS_PWR_OFF
				|| i == OFS_PROT_CLASS || i == OFS_PRIORITY_INTERRUPT_MGMT)
			c = CLS_EP;
		else if (i >= OFS_PRELOAD && i < OFS_FW_RESULT)
			c = CLS_EP;
		else if (i >= OFS_CONTEXT && i < OFS_EXT_PART)
			c = CLS_EP;
		else if (i == OFS_EXC_MASK || i == OFS_EXC_MASK + 8'h01)
			c = CLS_EP;
		else if (i == OFS_USER_PROT || i == OFS_BOOT_PROT)
			c = CLS_CP;
		else if (i == OFS_MODE_OP || i == OFS_FLUSH || i == OFS_CASE_TEMP
				|| i == OFS_BKOPS_GO || i == OFS_SANITIZE_GO)
			c = CLS_WO;
		else if (i == OFS_PROD_AWR_EN || i == OFS_PERIODIC || i == OFS_PROD_AWR)
			c = CLS_NVE;
		else if (i >= OFS_MAKER_PRIV && i <= OFS_MAKER_END)
			c = CLS_NVE;
		else if (i == OFS_SEC_REMOVAL || i == OFS_BARRIER || i == OFS_EXT_PART
				|| i == OFS_EXT_PART + 8'h01 || i == OFS_SECTOR_EMUL || i == OFS_SEC_BADBLK
				|| i == OFS_RST_PIN_FN || i == OFS_BACKGROUND_OPS_ENABLE || i == OFS_WRREL_SEL
				|| i == OFS_FW_LOCK)
			c = CLS_OTP;
		else if (i >= OFS_ENH_START && i <= OFS_PART_ATTR)
			c = CLS_OTP;
		else if ((i >= OFS_MAX_PRELOAD && i < OFS_PRELOAD) || i == OFS_FW_RESULT
				|| (i >= OFS_PACK_FAIL && i < OFS_CONTEXT)
				|| (i >= OFS_EXC_FLAGS && i < OFS_EXC_MASK)
				|| i == OFS_GROUPS_REL || (i >= OFS_FIRST_INIT && i < OFS_SECTOR_EMUL)
				|| i == OFS_PHYS_SECTOR || i == OFS_DDR_ID_PROG
				|| (i >= OFS_MAX_ENH && i <= OFS_PART_CAP)
				|| i == OFS_WRREL_CAPS || i == OFS_PROT_AREA)
			c = CLS_RO;
		return c;
	endfunction

	// default value of each byte, multi-byte fields least significant byte first
	function automatic logic [7:0] dflt_of(input logic [7:0] i);
		logic [7:0] d;
		logic [7:0] k;
		d = BYTE_ZERO;
		k = 8'h00;
		if (i >= OFS_MAX_PRELOAD && i < OFS_PRELOAD) begin
			k = i - OFS_MAX_PRELOAD;
			d = DFLT_MAX_PRELOAD[k[1:0]*8 +: 8];
		end else if (i >= OFS_MAX_ENH && i < OFS_PART_CAP) begin
			k = i - OFS_MAX_ENH;
			d = DFLT_MAX_ENH[k[1:0]*8 +: 8];
		end else if (i == OFS_SEC_REMOVAL)
			d = DFLT_SEC_REMOVAL;
		else if (i == OFS_DDR_ID_PROG)
			d = DFLT_DDR_ID_PROG;
		else if (i == OFS_PART_CAP)
			d = DFLT_PART_CAP;
		else if (i == OFS_WRREL_CAPS)
			d = DFLT_WRREL_CAPS;
		else if (i == OFS_WRREL_SEL)
			d = DFLT_WRREL_SEL;
		else if (i == OFS_PROT_AREA)
			d = DFLT_PROT_AREA;
		return d;
	endfunction

endpackage

//--- rtl/mfx_nvram.sv
// mfx_nvram: byte store standing in for the nonvolatile array behind the config bytes
`timescale 1ns/10ps

module mfx_nvram #(
	parameter int unsigned DW = 8,
	parameter int unsigned AW = 8
) (
	// clock
	input  wire logic          mclk_i,
	input  wire logic          ce_i,
	// write side
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	// read side
	input  wire logic          re_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [DW-1:0] rdata_o
);

	// ==========================================================================
	// storage
	// no reset on purpose: contents outlive power loss; validity is tracked outside
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// write port
	always_ff @(posedge mclk_i) begin
		if (ce_i && we_i)
			mem[waddr_i] <= wdata_i;
	end

	// registered read, old data on a same-address write
	always_ff @(posedge mclk_i) begin
		if (ce_i && re_i)
			rdata_o <= mem[raddr_i];
	end

endmodule // mfx_nvram

//--- rtl/mfx_vbyte.sv
// mfx_vbyte: one volatile config byte with its class-specific reset and write behaviour
`timescale 1ns/10ps

module mfx_vbyte #(
	parameter mfx_pkg::mfx_cls_t CLS  = mfx_pkg::CLS_EP,
	parameter logic [7:0]        DFLT = 8'h00
) (
	// clock and resets
	input  wire logic       mclk_i,
	input  wire logic       rstn_i,
	input  wire logic       ce_i,
	input  wire logic       hw_rst_i,
	input  wire logic       sw_rst_i,
	// write
	input  wire logic       wr_i,
	input  wire logic [7:0] wr_data_i,
	// state
	output logic      [7:0] q_o,
	output logic            acc_o
);

	logic       done;
	logic       sw_clears;
	logic       locked;

	// cleared-by-command classes only; the power-held class ignores the command
	assign sw_clears = (CLS != mfx_pkg::CLS_CP);
	// write-only bytes take a single programming until the next reset
	assign locked    = (CLS == mfx_pkg::CLS_WO) && done;
	assign acc_o     = wr_i && !locked;

	// reset beats a write in the same cycle
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			q_o  <= DFLT;
			done <= 1'b0;
		end else if (ce_i) begin
			if (hw_rst_i || (sw_rst_i && sw_clears)) begin
				q_o  <= DFLT;
				done <= 1'b0;
			end else if (acc_o) begin
				q_o  <= wr_data_i;
				done <= 1'b1;
			end
		end
	end

endmodule // mfx_vbyte

//--- verification/mfx_host_model.sv
// mfx_host_model: host controller driving the config array byte ports
`timescale 1ns/10ps

module mfx_host_model (
	// clock
	input  wire logic       mclk_i,
	// write side
	output mfx_pkg::mfx_wr_t wr_req_o,
	input  wire logic       wr_done_i,
	input  wire logic       wr_reject_i,
	// read side
	output logic            rd_en_o,
	output logic      [7:0] rd_idx_o,
	input  wire logic       rd_valid_i,
	input  wire logic [7:0] rd_data_i
);
	// ========
	// idle lines start quiet
	initial begin
		wr_req_o = '0;
		rd_en_o = 1'b0;
		rd_idx_o = 8'h00;
	end

	// ========
	// byte write; idle lines then show the inverse so stale values never pass
	task automatic write_byte(input logic [7:0] idx, input logic [7:0] dat,
			output logic [7:0] ans);
		@(negedge mclk_i);
		wr_req_o = '{en: 1'b1, idx: idx, data: dat};
		@(posedge mclk_i);
		@(negedge mclk_i);
		ans = {6'h00, wr_done_i, wr_reject_i};
		wr_req_o = '{en: 1'b0, idx: ~idx, data: ~dat};
	endtask

	task automatic read_byte(input logic [7:0] idx, output logic [7:0] dat);
		@(negedge mclk_i);
		rd_en_o = 1'b1;
		rd_idx_o = idx;
		@(posedge mclk_i);
		@(negedge mclk_i);
		rd_en_o = 1'b0;
		rd_idx_o = ~idx;
		@(posedge mclk_i);
		@(negedge mclk_i);
		dat = rd_valid_i ? rd_data_i : 8'hxx; // no valid, no data
	endtask
endmodule // mfx_host_model

//--- verification/tb_top.sv
// tb_top: table-driven bench for the extended config array
`timescale 1ns/10ps

module tb_top;
	// ========
	// signals
	typedef struct packed {
		logic       wr;
		logic [7:0] idx;
		logic [7:0] dat;
		logic [7:0] exp;
	} mfx_row_t;
	localparam int LIMIT = 4000;
	logic                 mclk_i;
	logic                 rstn_i;
	logic                 ce_i;
	logic                 hw_rst_i;
	logic                 sw_rst_i;
	logic                 nv_erase_i;
	mfx_pkg::mfx_wr_t     wr_req;
	logic                 wr_done;
	logic                 wr_reject;
	logic                 rd_en;
	logic [7:0]           rd_idx;
	logic                 rd_valid;
	logic [7:0]           rd_data;
	mfx_pkg::mfx_status_t status;
	mfx_pkg::mfx_cfg_t    cfg;
	logic [7:0]           got;
	int                   fail_count;
	int                   n_checks;
	int                   cycles;
	mfx_row_t             rows [0:39];

	// ========
	// design and host
	mfx_ext_cfg DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .hw_rst_i(hw_rst_i),
		.sw_rst_i(sw_rst_i), .nv_erase_i(nv_erase_i), .wr_req_i(wr_req), .wr_done_o(wr_done),
		.wr_reject_o(wr_reject), .rd_en_i(rd_en), .rd_idx_i(rd_idx), .rd_valid_o(rd_valid),
		.rd_data_o(rd_data), .status_i(status), .cfg_o(cfg));
	mfx_host_model host (.mclk_i(mclk_i), .wr_req_o(wr_req), .wr_done_i(wr_done),
		.wr_reject_i(wr_reject), .rd_en_o(rd_en), .rd_idx_o(rd_idx), .rd_valid_i(rd_valid),
		.rd_data_i(rd_data));

	always #5 mclk_i = ~mclk_i;

	// ========
	// checking
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// one row: a write checks its answer code (02 taken, 01 refused), a read the byte
	task automatic step(input mfx_row_t r);
		if (r.wr) begin
			host.write_byte(r.idx, r.dat, got);
		end else begin
			host.read_byte(r.idx, got);
		end
		check(got, r.exp);
	endtask

	// k: 0 power loss, 1 hardware reset, 2 command reset; held three cycles
	task automatic pulse(input int k);
		@(negedge mclk_i);
		rstn_i = (k != 0);
		hw_rst_i = (k == 1);
		sw_rst_i = (k == 2);
		repeat (3) @(negedge mclk_i);
		rstn_i = 1'b1;
		hw_rst_i = 1'b0;
		sw_rst_i = 1'b0;
	endtask

	// hang guard
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			print_verdict();
		end
	end

	// ========
	// main sequence
	initial begin
		mclk_i = 1'b0;
		rstn_i = 1'b0;
		ce_i = 1'b1;
		hw_rst_i = 1'b0;
		sw_rst_i = 1'b0;
		nv_erase_i = 1'b1;
		fail_count = 0;
		n_checks = 0;
		cycles = 0;
		status = '{fw_result: 8'h12, pack_fail: 8'h00, pack_state: 8'h00,
			exc_flags: 16'hbeef, groups_rel: 8'h00};
		rows = '{'{1'h0,8'ha8,8'h00,8'h20}, '{1'h0,8'ha6,8'h00,8'h15}, '{1'h0,8'ha0,8'h00,8'h07},
			'{1'h0,8'ha7,8'h00,8'h1f}, '{1'h0,8'h82,8'h00,8'h01}, '{1'h0,8'h10,8'h00,8'h09},
			'{1'h0,8'h1a,8'h00,8'h12}, '{1'h0,8'h36,8'h00,8'hef}, '{1'h0,8'h37,8'h00,8'hbe},
			'{1'h0,8'h87,8'h00,8'h00}, '{1'h0,8'h80,8'h00,8'h00}, '{1'h0,8'h81,8'h00,8'h00},
			'{1'h0,8'haa,8'h00,8'h00}, '{1'h0,8'hac,8'h00,8'h00}, '{1'h0,8'hae,8'h00,8'h00},
			'{1'h1,8'h1e,8'h5a,8'h02}, '{1'h0,8'h1e,8'h00,8'h5a}, '{1'h1,8'h1e,8'ha5,8'h02},
			'{1'h0,8'h1e,8'h00,8'ha5}, '{1'h1,8'h86,8'h3c,8'h02}, '{1'h1,8'h86,8'hc3,8'h01},
			'{1'h0,8'h86,8'h00,8'h3c}, '{1'h1,8'h84,8'h01,8'h02}, '{1'h0,8'h84,8'h00,8'h00},
			'{1'h1,8'h84,8'h02,8'h01}, '{1'h1,8'h83,8'h11,8'h02}, '{1'h1,8'h83,8'h22,8'h02},
			'{1'h0,8'h83,8'h00,8'h22}, '{1'h1,8'hab,8'h44,8'h02}, '{1'h0,8'hab,8'h00,8'h44},
			'{1'h1,8'ha6,8'h00,8'h01}, '{1'h0,8'ha6,8'h00,8'h15}, '{1'h1,8'h00,8'hff,8'h01},
			'{1'h1,8'h1a,8'hff,8'h01}, '{1'h1,8'h88,8'h78,8'h02}, '{1'h1,8'h89,8'h56,8'h02},
			'{1'h0,8'h88,8'h00,8'h78}, '{1'h0,8'h89,8'h00,8'h56}, '{1'h1,8'ha7,8'h03,8'h02},
			'{1'h0,8'ha7,8'h00,8'h03}};
		repeat (3) @(negedge mclk_i);
		rstn_i = 1'b1;
		nv_erase_i = 1'b0;
		for (int i = 0; i < 15; i++) begin
			host.read_byte(i[7:0], got);
			check(got, 8'h00);
		end
		foreach (rows[i]) begin
			step(rows[i]);
		end
		// trigger pulse, then cache level one cycle behind the cell
		host.write_byte(8'h20, 8'h01, got);
		check({7'h00, cfg.flush_req}, 8'h01);
		host.write_byte(8'ha4, 8'h01, got);
		check({7'h00, cfg.bkops_req}, 8'h01);
		host.write_byte(8'ha5, 8'h01, got);
		check({7'h00, cfg.sanitize_req}, 8'h01);
		host.write_byte(8'h0f, 8'h01, got);
		host.write_byte(8'h22, 8'h33, got);
		host.write_byte(8'h21, 8'h01, got);
		@(negedge mclk_i);
		check({7'h00, cfg.cache_on}, 8'h01);
		check({7'h00, cfg.cmdq_en}, 8'h01);
		check(cfg.pwr_off, 8'h33);
		check(cfg.mode_sel, 8'ha5);
		pulse(2);
		check({7'h00, cfg.cache_on}, 8'h00);
		check({7'h00, cfg.cmdq_en}, 8'h00);
		check(cfg.pwr_off, 8'h00);
		step('{1'h0, 8'h1e, 8'h00, 8'h00});
		step('{1'h0, 8'hab, 8'h00, 8'h44});
		step('{1'h0, 8'h83, 8'h00, 8'h22});
		step('{1'h0, 8'h86, 8'h00, 8'h3c});
		step('{1'h1, 8'h84, 8'h05, 8'h02});
		pulse(1);
		step('{1'h0, 8'hab, 8'h00, 8'h00});
		step('{1'h0, 8'h83, 8'h00, 8'h22});
		step('{1'h0, 8'ha7, 8'h00, 8'h03});
		pulse(0);
		step('{1'h0, 8'h83, 8'h00, 8'h22});
		step('{1'h0, 8'h86, 8'h00, 8'h3c});
		step('{1'h0, 8'h1e, 8'h00, 8'h00});
		step('{1'h1, 8'hab, 8'h55, 8'h02});
		step('{1'h0, 8'hab, 8'h00, 8'h55});
		print_verdict();
	end
endmodule // tb_top
